// ### verilog/tmc_pkg.sv
// constants shared by the transceiver mode control block
`default_nettype none
package tmc_pkg;
   // clock and timing
   localparam int unsigned CLK_PERIOD_PS = 5000;          // 200 MHz reference clock
   localparam int unsigned LOCK_TIME_PS  = 500000000;     // 500 us lock limit
   // longest time: rounded down to whole cycles
   localparam int unsigned LOCK_CYC      = LOCK_TIME_PS / CLK_PERIOD_PS;
   // two-wire target address; value arbitrary
   localparam logic [6:0]  TWI_ADDR      = 7'h3A;
   // register offsets in the two-wire space
   localparam logic [7:0]  STATUS_OFS    = 8'h6E;         // byte 110
   localparam logic [7:0]  CTRL_OFS      = 8'h80;
   localparam logic [7:0]  EQ_OFS        = 8'h81;
   localparam logic [7:0]  EMPH_OFS      = 8'h82;
   // field positions
   localparam int unsigned STATUS_LOS_BIT = 1;
   localparam int unsigned CTRL_OPT_BIT   = 0;
   localparam int unsigned CTRL_ELEC_BIT  = 1;
   localparam int unsigned CTRL_PASS_BIT  = 2;
   // reset values
   localparam logic [7:0]  CTRL_RST      = 8'h00;
   localparam logic [7:0]  EQ_RST        = 8'h00;
   localparam logic [7:0]  EMPH_RST      = 8'h00;
   localparam logic [7:0]  PTR_RST       = 8'h00;
   localparam logic [3:0]  BITS_PER_BYTE = 4'h8;
   // two-wire target states
   typedef enum logic [2:0] {
      TMC_IDLE = 3'b000,
      TMC_ADDR = 3'b001,
      TMC_ACK  = 3'b010,
      TMC_WR   = 3'b011,
      TMC_RD   = 3'b100,
      TMC_RACK = 3'b101
   } tmc_twi_state_t;
endpackage : tmc_pkg
`default_nettype wire

// ### verilog/tmc_cdr_if.sv
// clock-recovery control and lock status between top and lock timer
`default_nettype none
interface tmc_cdr_if;
   logic engage;      // stage engaged (not bypassed)
   logic traffic_ok;  // valid top-rate traffic present
   logic locked;      // lock reached
   modport ctrl  (output engage, output traffic_ok, input locked);
   modport timer (input engage, input traffic_ok, output locked);
endinterface : tmc_cdr_if
`default_nettype wire

// ### verilog/tmc_cdr_lock.sv
// lock timer for one clock-recovery stage
`default_nettype none
module tmc_cdr_lock #(
   parameter int unsigned LOCK_CYC = tmc_pkg::LOCK_CYC
) (
   // clock and reset
   input  wire logic     ref_clk,
   input  wire logic     rst_b,
   // control and status
   tmc_cdr_if.timer      cdr
);
   import tmc_pkg::*;

   localparam int unsigned CW = $clog2(LOCK_CYC + 1);
   localparam logic [CW-1:0] LAST = CW'(LOCK_CYC - 1);

   generate
      if (LOCK_CYC < 1)
      begin : g_bad_lock
         $error("LOCK_CYC must be at least one");
      end
   endgenerate

   logic [CW-1:0] cnt_r;
   logic          locked_r;

   // count valid traffic while engaged; lock lands no later than the limit
   always_ff @(posedge ref_clk)
   begin
      if (!rst_b)
      begin
         cnt_r    <= '0;
         locked_r <= 1'b0;
      end
      else if (!cdr.engage || !cdr.traffic_ok)
      begin
         cnt_r    <= '0;           // bypass or lost traffic drops lock
         locked_r <= 1'b0;
      end
      else if (!locked_r)
      begin
         if (cnt_r == LAST)
            locked_r <= 1'b1;
         else
            cnt_r <= cnt_r + CW'(1);
      end
   end

   assign cdr.locked = locked_r;
endmodule : tmc_cdr_lock
`default_nettype wire

// ### verilog/tmc_mode_ctrl.sv
// transceiver low-speed control, status and two-wire configuration target
//
// How it works
// - receive rate select high engages receive clock recovery; lock within 500 us.
// - receive rate select low bypasses receive clock recovery for legacy rates, unless optical loopback is on.
// - transmit rate select high engages transmit clock recovery; lock within 500 us.
// - transmit rate select low bypasses transmit clock recovery for lower rates, unless electrical loopback is on.
// - unconnected rate select reads low, so clock recovery is bypassed unless its loopback is on.
// - laser off while shutdown input high or open, on while low.
// - laser fault output high on fault, low in normal operation.
// - loss-of-signal output high when received power is below sensitivity.
// - presence pin is held to ground.
// - two-wire interface: clock pin and data pin, module is target.
// - optical loopback retransmits received optical data through clock recovery.
// - electrical loopback returns host transmit data through clock recovery.
// - pass-through mode also sends looped data outbound.
// - host selects input equalization setting at run time.
// - host selects output emphasis setting at run time.
// - loss-of-signal readable at byte 110, bit 1.
`default_nettype none
module tmc_mode_ctrl #(
   parameter int unsigned LOCK_CYC = tmc_pkg::LOCK_CYC,
   parameter int unsigned EQ_W     = 3,
   parameter int unsigned EMPH_W   = 3
) (
   // clock and reset
   input  wire logic              ref_clk,
   input  wire logic              rst_b,
   // host control pins (pad pull resistors resolve open pins)
   input  wire logic              receive_rate_sel,
   input  wire logic              transmit_rate_sel,
   input  wire logic              transmit_shutdown,
   // analogue front-end status
   input  wire logic              laser_fault_det,
   input  wire logic              rx_power_low,
   input  wire logic              rx_traffic_valid,
   input  wire logic              tx_traffic_valid,
   // host status pins
   output logic                   laser_fault,
   output logic                   receive_signal_lost,
   // presence pin, open-drain
   output logic                   module_presence_pin_out,
   output logic                   module_presence_pin_oe,
   // two-wire serial pins
   input  wire logic              twowire_clock_pin,
   input  wire logic              twowire_data_pin_in,
   output logic                   twowire_data_pin_out,
   output logic                   twowire_data_pin_oe,
   // datapath steering
   output logic                   laser_enable,
   output logic                   rx_cdr_engage,
   output logic                   tx_cdr_engage,
   output logic                   rx_cdr_locked,
   output logic                   tx_cdr_locked,
   output logic                   optical_loopback,
   output logic                   electrical_loopback,
   output logic                   laser_mute,
   output logic                   rd_out_mute,
   output logic [EQ_W-1:0]        eq_select,
   output logic [EMPH_W-1:0]      emph_select
);
   import tmc_pkg::*;

   generate
      if (EQ_W < 1 || EQ_W > 8 || EMPH_W < 1 || EMPH_W > 8)
      begin : g_bad_width
         $error("EQ_W and EMPH_W must lie in 1..8");
      end
   endgenerate

   // configuration fields
   logic              opt_lb_r;
   logic              elec_lb_r;
   logic              pass_r;
   logic [EQ_W-1:0]   eq_r;
   logic [EMPH_W-1:0] emph_r;

   // two-wire target state
   tmc_twi_state_t    st_r;
   logic              scl_d_r;
   logic              sda_d_r;
   logic [7:0]        sh_r;
   logic [3:0]        cnt_r;
   logic [7:0]        ptr_r;
   logic              rw_r;
   logic              ptr_next_r;
   logic              nack_r;
   logic              sda_oe_r;

   // pin status
   logic              los_r;
   logic              fault_r;

   logic              scl_rise;
   logic              scl_fall;
   logic              start_cond;
   logic              stop_cond;
   logic              wr_strobe;
   logic [7:0]        rd_data;

   tmc_cdr_if rx_cdr ();
   tmc_cdr_if tx_cdr ();

   // edges and bus conditions; pins are synchronous to ref_clk
   assign scl_rise   = twowire_clock_pin & ~scl_d_r;
   assign scl_fall   = ~twowire_clock_pin & scl_d_r;
   assign start_cond = twowire_clock_pin & scl_d_r & sda_d_r & ~twowire_data_pin_in;
   assign stop_cond  = twowire_clock_pin & scl_d_r & ~sda_d_r & twowire_data_pin_in;

   // a data byte (not the pointer) completes on this falling edge
   assign wr_strobe  = (st_r == TMC_WR) && scl_fall && (cnt_r == BITS_PER_BYTE) && !ptr_next_r;

   // read-back map; status is sampled live when the byte is loaded
   always_comb
   begin
      rd_data = 8'h00;
      unique case (ptr_r)
         STATUS_OFS: rd_data[STATUS_LOS_BIT] = los_r;
         CTRL_OFS:
         begin
            rd_data[CTRL_OPT_BIT]  = opt_lb_r;
            rd_data[CTRL_ELEC_BIT] = elec_lb_r;
            rd_data[CTRL_PASS_BIT] = pass_r;
         end
         EQ_OFS:   rd_data[EQ_W-1:0]   = eq_r;
         EMPH_OFS: rd_data[EMPH_W-1:0] = emph_r;
         default:  rd_data = 8'h00;                          // unmapped bytes read zero
      endcase
   end

   // previous pin levels for edge detection
   always_ff @(posedge ref_clk)
   begin
      if (!rst_b)
      begin
         scl_d_r <= 1'b1;
         sda_d_r <= 1'b1;
      end
      else
      begin
         scl_d_r <= twowire_clock_pin;
         sda_d_r <= twowire_data_pin_in;
      end
   end

   // two-wire target: start, address, pointer, write and read bytes
   always_ff @(posedge ref_clk)
   begin
      if (!rst_b)
      begin
         st_r       <= TMC_IDLE;
         sh_r       <= 8'h00;
         cnt_r      <= 4'h0;
         rw_r       <= 1'b0;
         ptr_next_r <= 1'b0;
         nack_r     <= 1'b0;
         sda_oe_r   <= 1'b0;
      end
      else if (start_cond)
      begin
         st_r     <= TMC_ADDR;
         cnt_r    <= 4'h0;
         sda_oe_r <= 1'b0;
      end
      else if (stop_cond)
      begin
         st_r     <= TMC_IDLE;
         sda_oe_r <= 1'b0;
      end
      else
      begin
         unique case (st_r)
            TMC_IDLE: sda_oe_r <= 1'b0;
            TMC_ADDR, TMC_WR:
            begin
               if (scl_rise && cnt_r != BITS_PER_BYTE)
               begin
                  sh_r  <= {sh_r[6:0], twowire_data_pin_in};
                  cnt_r <= cnt_r + 4'h1;
               end
               else if (scl_fall && cnt_r == BITS_PER_BYTE)
               begin
                  cnt_r <= 4'h0;
                  if (st_r == TMC_ADDR && sh_r[7:1] != TWI_ADDR)
                     st_r <= TMC_IDLE;                        // not ours: stay off the bus
                  else
                  begin
                     if (st_r == TMC_ADDR)
                     begin
                        rw_r       <= sh_r[0];
                        ptr_next_r <= ~sh_r[0];               // first written byte is the pointer
                     end
                     else
                        ptr_next_r <= 1'b0;
                     st_r     <= TMC_ACK;
                     sda_oe_r <= 1'b1;                        // pull data low to acknowledge
                  end
               end
            end
            TMC_ACK:
            begin
               if (scl_fall)
               begin
                  if (rw_r)
                  begin
                     sh_r     <= rd_data;
                     sda_oe_r <= ~rd_data[7];
                     st_r     <= TMC_RD;
                  end
                  else
                  begin
                     sda_oe_r <= 1'b0;
                     st_r     <= TMC_WR;
                  end
               end
            end
            TMC_RD:
            begin
               if (scl_rise)
                  cnt_r <= cnt_r + 4'h1;
               else if (scl_fall)
               begin
                  if (cnt_r == BITS_PER_BYTE)
                  begin
                     sda_oe_r <= 1'b0;                        // release for host acknowledge
                     cnt_r    <= 4'h0;
                     st_r     <= TMC_RACK;
                  end
                  else
                  begin
                     sda_oe_r <= ~sh_r[6];
                     sh_r     <= {sh_r[6:0], 1'b0};
                  end
               end
            end
            TMC_RACK:
            begin
               if (scl_rise)
                  nack_r <= twowire_data_pin_in;
               else if (scl_fall)
               begin
                  if (nack_r)
                     st_r <= TMC_IDLE;                        // host ended the read
                  else
                  begin
                     sh_r     <= rd_data;
                     sda_oe_r <= ~rd_data[7];
                     st_r     <= TMC_RD;
                  end
               end
            end
            default:
            begin
               st_r     <= TMC_IDLE;
               sda_oe_r <= 1'b0;
            end
         endcase
      end
   end

   // byte pointer: set by the first write byte, advances per byte transferred
   always_ff @(posedge ref_clk)
   begin
      if (!rst_b)
         ptr_r <= PTR_RST;
      else if ((st_r == TMC_WR) && scl_fall && (cnt_r == BITS_PER_BYTE))
         ptr_r <= ptr_next_r ? sh_r : ptr_r + 8'h01;
      else if ((st_r == TMC_RD) && scl_fall && (cnt_r == BITS_PER_BYTE))
         ptr_r <= ptr_r + 8'h01;
   end

   // writable configuration fields
   always_ff @(posedge ref_clk)
   begin
      if (!rst_b)
      begin
         opt_lb_r  <= CTRL_RST[CTRL_OPT_BIT];
         elec_lb_r <= CTRL_RST[CTRL_ELEC_BIT];
         pass_r    <= CTRL_RST[CTRL_PASS_BIT];
         eq_r      <= EQ_RST[EQ_W-1:0];
         emph_r    <= EMPH_RST[EMPH_W-1:0];
      end
      else if (wr_strobe)
      begin
         unique case (ptr_r)
            CTRL_OFS:
            begin
               opt_lb_r  <= sh_r[CTRL_OPT_BIT];
               elec_lb_r <= sh_r[CTRL_ELEC_BIT];
               pass_r    <= sh_r[CTRL_PASS_BIT];
            end
            EQ_OFS:   eq_r   <= sh_r[EQ_W-1:0];
            EMPH_OFS: emph_r <= sh_r[EMPH_W-1:0];
            default:  ;                                       // other bytes ignore writes
         endcase
      end
   end

   // status pins follow the front-end detectors, one flop late
   always_ff @(posedge ref_clk)
   begin
      if (!rst_b)
      begin
         los_r   <= 1'b0;
         fault_r <= 1'b0;
      end
      else
      begin
         los_r   <= rx_power_low;
         fault_r <= laser_fault_det;
      end
   end

   // datapath steering; loopback forces its recovery stage in,
   // since a wrapped signal is always cleaned up before it leaves
   always_ff @(posedge ref_clk)
   begin
      if (!rst_b)
      begin
         laser_enable  <= 1'b0;
         rx_cdr_engage <= 1'b0;
         tx_cdr_engage <= 1'b0;
         laser_mute    <= 1'b0;
         rd_out_mute   <= 1'b0;
      end
      else
      begin
         laser_enable  <= ~transmit_shutdown;
         rx_cdr_engage <= receive_rate_sel | opt_lb_r;
         tx_cdr_engage <= transmit_rate_sel | elec_lb_r;
         laser_mute    <= elec_lb_r & ~pass_r;
         rd_out_mute   <= opt_lb_r & ~pass_r;
      end
   end

   // rate selects are used as given; no cross-check, since they may differ
   assign rx_cdr.engage     = rx_cdr_engage;
   assign rx_cdr.traffic_ok = rx_traffic_valid;
   assign tx_cdr.engage     = tx_cdr_engage;
   assign tx_cdr.traffic_ok = tx_traffic_valid;

   tmc_cdr_lock #(.LOCK_CYC(LOCK_CYC)) u_rx_lock (
      .ref_clk (ref_clk),
      .rst_b   (rst_b),
      .cdr     (rx_cdr.timer)
   );

   tmc_cdr_lock #(.LOCK_CYC(LOCK_CYC)) u_tx_lock (
      .ref_clk (ref_clk),
      .rst_b   (rst_b),
      .cdr     (tx_cdr.timer)
   );

   // outputs
   assign rx_cdr_locked           = rx_cdr.locked;
   assign tx_cdr_locked           = tx_cdr.locked;
   assign laser_fault             = fault_r;
   assign receive_signal_lost     = los_r;
   assign module_presence_pin_out = 1'b0;
   assign module_presence_pin_oe  = 1'b1;
   assign twowire_data_pin_out    = 1'b0;                     // open drain: only pulls low
   assign twowire_data_pin_oe     = sda_oe_r;
   assign optical_loopback        = opt_lb_r;
   assign electrical_loopback     = elec_lb_r;
   assign eq_select               = eq_r;
   assign emph_select             = emph_r;
endmodule : tmc_mode_ctrl
`default_nettype wire

// ### bench/tmc_host_model.sv
// host controller model driving the module two-wire pins
`default_nettype none
module tmc_host_model
   import tmc_pkg::*;
(
   // clock
   input  wire logic ref_clk,
   // two-wire pins; sda_low pulls data down, pull-up gives high
   output var  logic scl,
   output var  logic sda_low,
   input  wire logic sda
);
   timeunit 1ns;
   timeprecision 1ps;

   // idle bus: both lines released
   initial
   begin
      scl = 1'b1;
      sda_low = 1'b0;
   end

   task automatic w(input int n);
      repeat (n) @(posedge ref_clk);
   endtask : w

   // one pulse; data moves mid-low, never near a clock edge
   task automatic bit_x(input logic b, output logic r);
      sda_low <= !b;
      w(3);
      scl <= 1'b1;
      w(3);
      r = sda;
      w(1);
      scl <= 1'b0;
      w(3);
   endtask : bit_x

   // start or repeated start: data falls while clock high
   task automatic start();
      w(1);
      sda_low <= 1'b0;
      w(2);
      scl <= 1'b1;
      w(3);
      sda_low <= 1'b1;
      w(3);
      scl <= 1'b0;
      w(3);
   endtask : start

   // stop: data rises while clock high
   task automatic stop();
      sda_low <= 1'b1;
      w(3);
      scl <= 1'b1;
      w(3);
      sda_low <= 1'b0;
      w(3);
   endtask : stop

   // byte msb first, then ninth bit m from the host
   task automatic xfer(input logic [7:0] d, input logic m, output logic [7:0] q, output logic a);
      for (int i = 7; i >= 0; i--)
         bit_x(d[i], q[i]);
      bit_x(m, a);
   endtask : xfer

   // write one byte; a low when all bytes acknowledged
   task automatic wr(input logic [7:0] o, input logic [7:0] d, output logic a);
      logic [7:0] q;
      logic [2:0] k;
      start();
      xfer({TWI_ADDR, 1'b0}, 1'b1, q, k[0]);
      xfer(o, 1'b1, q, k[1]);
      xfer(d, 1'b1, q, k[2]);
      stop();
      a = |k;
   endtask : wr

   // read one byte; the host refuses it to end the read
   task automatic rd(input logic [7:0] o, output logic [7:0] d, output logic a);
      logic [7:0] q;
      logic [2:0] k;
      start();
      xfer({TWI_ADDR, 1'b0}, 1'b1, q, k[0]);
      xfer(o, 1'b1, q, k[1]);
      start();
      xfer({TWI_ADDR, 1'b1}, 1'b1, q, k[2]);
      xfer(8'hFF, 1'b1, d, q[0]);
      stop();
      a = |k;
   endtask : rd
endmodule : tmc_host_model
`default_nettype wire

// ### bench/tmc_mode_ctrl_properties.sv
// assertion checker for the transceiver mode control block
`default_nettype none
module tmc_mode_ctrl_props #(
   parameter int unsigned LOCK_CYC = 20
) (
   // clock and reset
   input wire logic ref_clk,
   input wire logic rst_b,
   // inputs
   input wire logic receive_rate_sel,
   input wire logic transmit_rate_sel,
   input wire logic transmit_shutdown,
   input wire logic laser_fault_det,
   input wire logic rx_power_low,
   input wire logic rx_traffic_valid,
   input wire logic tx_traffic_valid,
   // outputs
   input wire logic laser_fault,
   input wire logic receive_signal_lost,
   input wire logic module_presence_pin_out,
   input wire logic module_presence_pin_oe,
   input wire logic twowire_data_pin_out,
   input wire logic twowire_data_pin_oe,
   input wire logic laser_enable,
   input wire logic rx_cdr_engage,
   input wire logic tx_cdr_engage,
   input wire logic rx_cdr_locked,
   input wire logic tx_cdr_locked,
   input wire logic optical_loopback,
   input wire logic electrical_loopback,
   input wire logic laser_mute,
   input wire logic rd_out_mute
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rst_b);

   // run of engaged edges with traffic; bounds the receive lock wait
   int unsigned run_r;
   always_ff @(posedge ref_clk)
      if (!rst_b || !(rx_cdr_engage && rx_traffic_valid))
         run_r <= 0;
      else
         run_r <= run_r + 1;

   // same run for the transmit stage; catches a lock that comes too late
   int unsigned run_tx_r;
   always_ff @(posedge ref_clk)
      if (!rst_b || !(tx_cdr_engage && tx_traffic_valid))
         run_tx_r <= 0;
      else
         run_tx_r <= run_tx_r + 1;

   property p_pres;
      module_presence_pin_oe && !module_presence_pin_out && !twowire_data_pin_out;
   endproperty
   a_pres: assert property (p_pres) else $error("presence or data pin level wrong");
   property p_laser;
      $past(rst_b) |-> laser_enable == !$past(transmit_shutdown);
   endproperty
   a_laser: assert property (p_laser) else $error("laser enable wrong");
   property p_fault;
      $past(rst_b) |-> laser_fault == $past(laser_fault_det);
   endproperty
   a_fault: assert property (p_fault) else $error("laser fault wrong");
   property p_los;
      $past(rst_b) |-> receive_signal_lost == $past(rx_power_low);
   endproperty
   a_los: assert property (p_los) else $error("signal lost wrong");
   property p_rx_eng;
      $past(rst_b) |-> rx_cdr_engage == ($past(receive_rate_sel) || $past(optical_loopback));
   endproperty
   a_rx_eng: assert property (p_rx_eng) else $error("rx engage wrong");
   property p_tx_eng;
      $past(rst_b) |-> tx_cdr_engage == ($past(transmit_rate_sel) || $past(electrical_loopback));
   endproperty
   a_tx_eng: assert property (p_tx_eng) else $error("tx engage wrong");
   property p_rx_lock;
      run_r > LOCK_CYC + 1 |-> rx_cdr_locked;
   endproperty
   a_rx_lock: assert property (p_rx_lock) else $error("rx lock late");
   property p_tx_lock;
      $rose(tx_cdr_locked) |-> $past(tx_cdr_engage && tx_traffic_valid, 8);
   endproperty
   a_tx_lock: assert property (p_tx_lock) else $error("tx lock without cause");
   property p_tx_late;
      run_tx_r > LOCK_CYC + 1 |-> tx_cdr_locked;
   endproperty
   a_tx_late: assert property (p_tx_late) else $error("tx lock late");
   property p_mute;
      (rd_out_mute -> $past(optical_loopback)) && (laser_mute -> $past(electrical_loopback));
   endproperty
   a_mute: assert property (p_mute) else $error("mute without loopback");

   c_lock: cover property ($rose(rx_cdr_locked));
   c_ack: cover property ($rose(twowire_data_pin_oe));
   c_mute: cover property ($rose(laser_mute));
endmodule : tmc_mode_ctrl_props

bind tmc_mode_ctrl tmc_mode_ctrl_props #(.LOCK_CYC(LOCK_CYC)) props_u (.*);
`default_nettype wire

// ### bench/tmc_mode_ctrl_tb_top.sv
// self-checking testbench for the transceiver mode control block
`default_nettype none
module tmc_mode_ctrl_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   import tmc_pkg::*;
   logic ref_clk, rst_b, receive_rate_sel, transmit_rate_sel, transmit_shutdown;
   logic laser_fault_det, rx_power_low, rx_traffic_valid, tx_traffic_valid, host_low;
   logic laser_fault, receive_signal_lost, module_presence_pin_out, module_presence_pin_oe;
   logic twowire_clock_pin, twowire_data_pin_in, twowire_data_pin_out, twowire_data_pin_oe;
   logic laser_enable, rx_cdr_engage, tx_cdr_engage, rx_cdr_locked, tx_cdr_locked;
   logic optical_loopback, electrical_loopback, laser_mute, rd_out_mute;
   logic [2:0] eq_select, emph_select;
   int err_count, n_tests;

   // open-drain data line with pull-up
   assign twowire_data_pin_in = !(host_low || (twowire_data_pin_oe && !twowire_data_pin_out));
   // short lock count keeps the run brief
   tmc_mode_ctrl #(.LOCK_CYC(20)) dut_u (.*);
   tmc_host_model host_u (.ref_clk(ref_clk), .scl(twowire_clock_pin), .sda_low(host_low), .sda(twowire_data_pin_in));

   initial
   begin
      ref_clk = 1'b0;
      forever #2.5 ref_clk = ~ref_clk;
   end

   task automatic hold(input int n);
      repeat (n) @(posedge ref_clk);
      @(negedge ref_clk);
   endtask : hold

   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      n_tests++;
      if (got !== exp)
      begin
         err_count++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk

   task automatic final_report();
      if (err_count == 0 && n_tests > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask : final_report

   // every combination of shutdown, fault and low power
   task automatic t_pins();
      for (int i = 0; i < 8; i++)
      begin
         @(posedge ref_clk);
         transmit_shutdown <= i[0];
         laser_fault_det <= i[1];
         rx_power_low <= i[2];
         hold(2);
         chk({5'h0, laser_enable, laser_fault, receive_signal_lost}, {5'h0, !i[0], i[1], i[2]});
         chk({6'h0, module_presence_pin_oe, module_presence_pin_out}, 8'h02);
      end
   endtask : t_pins

   // split rate selects, as during speed negotiation, then both high, then both low
   task automatic t_rate();
      @(posedge ref_clk);
      receive_rate_sel <= 1'b1;
      rx_traffic_valid <= 1'b1;
      tx_traffic_valid <= 1'b1;
      hold(25);
      chk({4'h0, rx_cdr_engage, tx_cdr_engage, rx_cdr_locked, tx_cdr_locked}, 8'h0A);
      @(posedge ref_clk);
      transmit_rate_sel <= 1'b1;
      rx_traffic_valid <= 1'b0;
      hold(25);
      chk({4'h0, rx_cdr_engage, tx_cdr_engage, rx_cdr_locked, tx_cdr_locked}, 8'h0D);
      @(posedge ref_clk);
      receive_rate_sel <= 1'b0;
      transmit_rate_sel <= 1'b0;
      hold(3);
      chk({4'h0, rx_cdr_engage, tx_cdr_engage, rx_cdr_locked, tx_cdr_locked}, 8'h00);
   endtask : t_rate

   // loopback and pass-through settings, readback, then reset mid-run
   task automatic t_cfg();
      logic [7:0] tbl [4] = '{8'h01, 8'h02, 8'h05, 8'h06};
      logic [7:0] v, q;
      logic a;
      for (int i = 0; i < 4; i++)
      begin
         v = tbl[i];
         host_u.wr(CTRL_OFS, v, a);
         chk({7'h0, a}, 8'h00);
         hold(2);
         chk({2'h0, optical_loopback, electrical_loopback, rd_out_mute, laser_mute, rx_cdr_engage, tx_cdr_engage},
             {2'h0, v[0], v[1], v[0] & !v[2], v[1] & !v[2], v[0], v[1]});
         host_u.rd(CTRL_OFS, q, a);
         chk(q, v);
      end
      @(posedge ref_clk);
      rst_b <= 1'b0;
      hold(2);
      chk({6'h0, optical_loopback, electrical_loopback}, 8'h00);
      @(posedge ref_clk);
      rst_b <= 1'b1;
   endtask : t_cfg

   // every equalization and emphasis setting while running
   task automatic t_eq();
      logic a;
      for (int i = 0; i < 8; i++)
      begin
         host_u.wr(EQ_OFS, i[7:0], a);
         host_u.wr(EMPH_OFS, 8'(7 - i), a);
         hold(1);
         chk({2'h0, eq_select, emph_select}, {2'h0, i[2:0], 3'(7 - i)});
      end
   endtask : t_eq

   // status byte follows the loss-of-signal input
   task automatic t_status();
      logic [7:0] q;
      logic a;
      for (int i = 1; i >= 0; i--)
      begin
         @(posedge ref_clk);
         rx_power_low <= i[0];
         host_u.rd(STATUS_OFS, q, a);
         chk(q & 8'h02, {6'h0, i[0], 1'b0});
      end
   endtask : t_status

   // foreign address refused; unmapped byte acked and reads zero
   task automatic t_bad();
      logic [7:0] q;
      logic a;
      host_u.start();
      host_u.xfer({TWI_ADDR ^ 7'h01, 1'b0}, 1'b1, q, a);
      host_u.stop();
      chk({7'h0, a}, 8'h01);
      host_u.wr(8'h90, 8'hA5, a);
      chk({7'h0, a}, 8'h00);
      host_u.rd(8'h90, q, a);
      chk(q, 8'h00);
   endtask : t_bad

   initial
   begin
      err_count = 0;
      n_tests = 0;
      rst_b = 1'b0;
      transmit_shutdown = 1'b1;
      {receive_rate_sel, transmit_rate_sel, laser_fault_det} = 3'h0;
      {rx_power_low, rx_traffic_valid, tx_traffic_valid} = 3'h0;
      repeat (6) @(posedge ref_clk);
      rst_b <= 1'b1;
      t_pins();
      t_rate();
      t_cfg();
      t_eq();
      t_status();
      t_bad();
      final_report();
   end

   // watchdog well beyond the expected run of some 9100 cycles
   initial
   begin
      repeat (60000) @(posedge ref_clk);
      err_count++;
      final_report();
   end
endmodule : tmc_mode_ctrl_tb_top
`default_nettype wire
